// ---- shared/cwu_consts.svh ----
// register offsets, field positions, reset values and timing counts of the waveform unit
`ifndef CWU_CONSTS_SVH
`define CWU_CONSTS_SVH

`define CWU_ADDR_W        6
`define CWU_DATA_W        32
`define CWU_REG_CTRL      6'h00
`define CWU_REG_POL       6'h04
`define CWU_REG_CLK       6'h08
`define CWU_REG_SRC       6'h0C
`define CWU_REG_STEER     6'h10
`define CWU_REG_SDCTL     6'h14
`define CWU_REG_SDEN      6'h18
`define CWU_REG_DBR       6'h1C
`define CWU_REG_DBF       6'h20
`define CWU_REG_STAT      6'h24

`define CWU_EN_BIT        7
`define CWU_LD_BIT        6
`define CWU_IN_BIT        5
`define CWU_SD_BIT        7
`define CWU_REN_BIT       6

`define CWU_MODE_ASTEER   3'h0
`define CWU_MODE_SSTEER   3'h1
`define CWU_MODE_FWD      3'h2
`define CWU_MODE_REV      3'h3
`define CWU_MODE_HALF     3'h4
`define CWU_MODE_PUSH     3'h5

`define CWU_WAIT_RST      1'h1
`define CWU_OK_RST        1'h1

// fast oscillator modelled as a tick every CWU_OSC_DIV system clocks
`define CWU_OSC_DIV       4'h4

`endif

// ---- shared/cwu_pkg.sv ----
// types shared by the waveform unit
package cwu_pkg;
    typedef logic [31:0] cwu_word_t;
    typedef logic [5:0]  cwu_db_t;

    typedef struct packed {
        logic       wait_q;
        cwu_word_t  rdata;
        logic       en;
        logic       ld;
        logic       ld_fall;
        logic [2:0] mode;
        logic [3:0] pol;
        logic       cs;
        logic [1:0] src;
        logic [3:0] steer;
        logic [3:0] steer_sync;
        logic       shutdown;
        logic       ren;
        logic [1:0] lvl_bd;
        logic [1:0] lvl_ac;
        logic [3:0] sd_en;
        cwu_db_t    dbr;
        cwu_db_t    dbf;
        cwu_db_t    dbr_buf;
        cwu_db_t    dbf_buf;
        logic       irq;
        logic       hold;
        logic       data_s1;
        logic       data_s2;
        logic       data_prev;
        logic [3:0] sd_s1;
        logic [3:0] sd_s2;
        logic [3:0] osc_cnt;
        logic       rev;
        logic       pp_sel;
        cwu_db_t    rcnt;
        cwu_db_t    fcnt;
        logic       rrun;
        logic       frun;
        logic       rok;
        logic       fok;
        logic [3:0] outs;
        logic       osc_keep;
    } cwu_state_s;
endpackage

// ---- rtl/cwu_deadband.sv ----
// dead-band and auto-shutdown waveform unit with Avalon-MM register slave
`timescale 1ns/1ps
`include "cwu_consts.svh"

module cwu_deadband (
    input  wire logic              MCLK_IN,             // 200 MHz system clock
    input  wire logic              SYS_RST_IN,          // async reset, active high
    input  wire logic [5:0]        AVS_ADDRESS_IN,      // byte address
    input  wire logic              AVS_READ_IN,         // read request
    input  wire logic              AVS_WRITE_IN,        // write request
    input  wire logic [3:0]        AVS_BYTEENABLE_IN,   // byte lanes
    input  wire cwu_pkg::cwu_word_t AVS_WRITEDATA_IN,   // write data
    output logic                   AVS_WAITREQUEST_OUT, // stall
    output cwu_pkg::cwu_word_t     AVS_READDATA_OUT,    // read data
    input  wire logic [3:0]        DATA_SRC_IN,         // candidate modulating sources
    input  wire logic [3:0]        SHUTDOWN_N_IN,       // fault inputs, active low
    input  wire logic              SLEEP_IN,            // system clock gated in sleep
    output logic                   OUTPUT_FIRST_OUT,    // first output
    output logic                   OUTPUT_SECOND_OUT,   // second output
    output logic                   OUTPUT_THIRD_OUT,    // third output
    output logic                   OUTPUT_FOURTH_OUT,   // fourth output
    output logic                   SHUTDOWN_IRQ_FLAG_OUT, // sticky shutdown flag
    output logic                   FAST_OSC_KEEP_OUT    // keep fast oscillator running
);
    import cwu_pkg::*;

    cwu_state_s s;
    cwu_state_s n;

    logic       wr;
    logic       rd_req;
    logic       din;
    logic       rise;
    logic       fall;
    logic       tick;
    logic       sd_cond;
    logic       hb;
    logic       fb;
    logic       chg_fwd;
    logic       chg_rev;
    logic       r_start;
    logic       f_start;
    logic [3:0] act;
    logic [3:0] ovr;
    logic [3:0] st_eff;
    logic [6:0] r_next;
    logic [6:0] f_next;

    always_comb begin
        n = s;

        // bus: request seen with wait high -> answer next cycle, write lands then
        // only a read refreshes read data, so it stands until the next read answer
        rd_req = AVS_READ_IN & s.wait_q;
        wr = AVS_WRITE_IN & ~s.wait_q & AVS_BYTEENABLE_IN[0];
        n.wait_q = ~((AVS_READ_IN | AVS_WRITE_IN) & s.wait_q);
        if (rd_req) begin
            n.rdata = '0;
            unique case (AVS_ADDRESS_IN)
                `CWU_REG_CTRL:  n.rdata[7:0] = {s.en, s.ld, 3'h0, s.mode};
                `CWU_REG_POL:   n.rdata[7:0] = {2'h0, s.data_s2, 1'h0, s.pol};
                `CWU_REG_CLK:   n.rdata[0] = s.cs;
                `CWU_REG_SRC:   n.rdata[1:0] = s.src;
                `CWU_REG_STEER: n.rdata[3:0] = s.steer;
                `CWU_REG_SDCTL: n.rdata[7:0] = {s.shutdown, s.ren, s.lvl_bd, s.lvl_ac, 2'h0};
                `CWU_REG_SDEN:  n.rdata[3:0] = s.sd_en;
                `CWU_REG_DBR:   n.rdata[5:0] = s.dbr;
                `CWU_REG_DBF:   n.rdata[5:0] = s.dbf;
                `CWU_REG_STAT:  n.rdata[0] = s.irq;
                default:        n.rdata = '0;
            endcase
        end

        // input synchronisers; only the second stage is looked at
        n.data_s1 = DATA_SRC_IN[s.src];
        n.data_s2 = s.data_s1;
        n.data_prev = s.data_s2;
        n.sd_s1 = SHUTDOWN_N_IN;
        n.sd_s2 = s.sd_s1;
        din = s.data_s2;
        rise = din & ~s.data_prev;
        fall = ~din & s.data_prev;

        // dead-band clock: system clock stops in sleep, fast oscillator does not
        n.osc_cnt = (s.osc_cnt == `CWU_OSC_DIV - 4'h1) ? 4'h0 : s.osc_cnt + 4'h1;
        tick = s.cs ? (s.osc_cnt == 4'h0) : ~SLEEP_IN;
        n.osc_keep = s.en & s.cs;

        // plain register writes
        if (wr) begin
            unique case (AVS_ADDRESS_IN)
                `CWU_REG_CTRL: begin
                    n.en = AVS_WRITEDATA_IN[`CWU_EN_BIT];
                    n.mode = AVS_WRITEDATA_IN[2:0];
                    // a request in the enabling write itself is dropped
                    if (AVS_WRITEDATA_IN[`CWU_LD_BIT] & s.en) begin
                        n.ld = 1'b1;
                    end
                end
                `CWU_REG_POL:   n.pol = AVS_WRITEDATA_IN[3:0];
                `CWU_REG_CLK:   n.cs = AVS_WRITEDATA_IN[0];
                `CWU_REG_SRC:   n.src = AVS_WRITEDATA_IN[1:0];
                `CWU_REG_STEER: n.steer = AVS_WRITEDATA_IN[3:0];
                `CWU_REG_SDCTL: begin
                    n.ren = AVS_WRITEDATA_IN[`CWU_REN_BIT];
                    n.lvl_bd = AVS_WRITEDATA_IN[5:4];
                    n.lvl_ac = AVS_WRITEDATA_IN[3:2];
                end
                `CWU_REG_SDEN:  n.sd_en = AVS_WRITEDATA_IN[3:0];
                `CWU_REG_DBR: begin
                    n.dbr = AVS_WRITEDATA_IN[5:0];
                    if (!s.en) begin
                        n.dbr_buf = AVS_WRITEDATA_IN[5:0];
                    end
                end
                `CWU_REG_DBF: begin
                    n.dbf = AVS_WRITEDATA_IN[5:0];
                    if (!s.en) begin
                        n.dbf_buf = AVS_WRITEDATA_IN[5:0];
                    end
                end
                `CWU_REG_STAT: begin
                    if (AVS_WRITEDATA_IN[0]) begin
                        n.irq = 1'b0;
                    end
                end
                default: ;
            endcase
        end

        // buffered load: first falling edge after request, then next rising edge
        if (!s.en) begin
            n.ld = 1'b0;
            n.ld_fall = 1'b0;
        end else if (s.ld & s.ld_fall & rise) begin
            n.dbr_buf = s.dbr;
            n.dbf_buf = s.dbf;
            n.ld = 1'b0;
            n.ld_fall = 1'b0;
        end else if (s.ld & fall) begin
            n.ld_fall = 1'b1;
        end

        // shutdown: level-sensitive on enabled, active-low inputs
        sd_cond = s.en & |(s.sd_en & ~s.sd_s2);
        if (s.ren & s.shutdown & ~sd_cond) begin
            n.shutdown = 1'b0;
        end
        if (wr && AVS_ADDRESS_IN == `CWU_REG_SDCTL) begin
            if (AVS_WRITEDATA_IN[`CWU_SD_BIT]) begin
                n.shutdown = 1'b1;
            end else if (!sd_cond) begin
                n.shutdown = 1'b0;
            end
        end
        if (n.en & ~s.en) begin
            n.shutdown = 1'b1;
        end
        if (sd_cond) begin
            n.shutdown = 1'b1;
        end
        // flag set wins over a clear in the same cycle
        if (n.shutdown & ~s.shutdown) begin
            n.irq = 1'b1;
        end
        // outputs stay overridden until the first rising data edge after clear
        if (n.shutdown | ~s.en) begin
            n.hold = 1'b1;
        end else if (s.hold & rise) begin
            n.hold = 1'b0;
        end

        // mode decode and direction tracking
        hb = (s.mode == `CWU_MODE_HALF);
        fb = (s.mode == `CWU_MODE_FWD) | (s.mode == `CWU_MODE_REV);
        chg_fwd = fb & rise & s.rev & ~s.mode[0];
        chg_rev = fb & rise & ~s.rev & s.mode[0];
        if (fb & rise) begin
            n.rev = s.mode[0];
        end
        if (rise & (s.mode == `CWU_MODE_PUSH)) begin
            n.pp_sel = ~s.pp_sel;
        end
        if (rise) begin
            n.steer_sync = s.steer;
        end
        r_start = (hb & rise) | chg_rev;
        f_start = (hb & fall) | chg_fwd;

        // rising / reverse dead-band counter
        r_next = {1'b0, s.rcnt} + 7'h01;
        if (!s.en) begin
            n.rrun = 1'b0;
            n.rok = `CWU_OK_RST;
        end else if (r_start) begin
            n.rcnt = '0;
            n.rok = (s.dbr_buf == '0);
            n.rrun = (s.dbr_buf != '0);
        end else if (hb & fall) begin
            n.rrun = 1'b0;
            n.rok = 1'b0;
        end else if (s.rrun & tick) begin
            n.rcnt = r_next[5:0];
            if (r_next >= {1'b0, s.dbr_buf}) begin
                n.rok = 1'b1;
                n.rrun = 1'b0;
            end
        end

        // falling / forward dead-band counter; counting ticks from an unaligned
        // edge gives count-1..count periods
        f_next = {1'b0, s.fcnt} + 7'h01;
        if (!s.en) begin
            n.frun = 1'b0;
            n.fok = `CWU_OK_RST;
        end else if (f_start) begin
            n.fcnt = '0;
            n.fok = (s.dbf_buf == '0);
            n.frun = (s.dbf_buf != '0);
        end else if (hb & rise) begin
            n.frun = 1'b0;
            n.fok = 1'b0;
        end else if (s.frun & tick) begin
            n.fcnt = f_next[5:0];
            if (f_next >= {1'b0, s.dbf_buf}) begin
                n.fok = 1'b1;
                n.frun = 1'b0;
            end
        end

        // active levels, bit0 = first .. bit3 = fourth
        st_eff = (s.mode == `CWU_MODE_SSTEER) ? n.steer_sync : s.steer;
        act = 4'h0;
        unique case (s.mode)
            `CWU_MODE_HALF: begin
                act[0] = din & n.rok;
                act[1] = ~din & n.fok;
                act[2] = act[0];
                act[3] = act[1];
            end
            `CWU_MODE_FWD, `CWU_MODE_REV: begin
                act[0] = ~n.rev;
                act[2] = n.rev;
                act[1] = n.rev & din & n.rok;
                act[3] = ~n.rev & din & n.fok;
            end
            `CWU_MODE_PUSH: begin
                act[0] = din & ~n.pp_sel;
                act[1] = din & n.pp_sel;
                act[2] = act[0];
                act[3] = act[1];
            end
            `CWU_MODE_ASTEER, `CWU_MODE_SSTEER: begin
                act = st_eff & {4{din}};
            end
            default: act = 4'h0;
        endcase
        act = act ^ s.pol;
        if (s.mode[2:1] == 2'h0) begin
            act = act & st_eff;
        end

        // override levels are not subject to polarity
        ovr = {s.lvl_bd[1], s.lvl_ac[1], s.lvl_bd[0], s.lvl_ac[0]};
        if (s.mode[2:1] == 2'h0) begin
            ovr = (ovr & st_eff) | (act & ~st_eff);
        end

        if (!s.en) begin
            n.outs = 4'h0;
        end else if (n.hold | sd_cond) begin
            n.outs = ovr;
        end else begin
            n.outs = act;
        end
    end

    always_ff @(posedge MCLK_IN or posedge SYS_RST_IN) begin
        if (SYS_RST_IN) begin
            s <= '0;
            s.wait_q <= `CWU_WAIT_RST;
            s.rok <= `CWU_OK_RST;
            s.fok <= `CWU_OK_RST;
        end else begin
            s <= n;
        end
    end

    assign AVS_WAITREQUEST_OUT = s.wait_q;
    assign AVS_READDATA_OUT = s.rdata;
    assign OUTPUT_FIRST_OUT = s.outs[0];
    assign OUTPUT_SECOND_OUT = s.outs[1];
    assign OUTPUT_THIRD_OUT = s.outs[2];
    assign OUTPUT_FOURTH_OUT = s.outs[3];
    assign SHUTDOWN_IRQ_FLAG_OUT = s.irq;
    assign FAST_OSC_KEEP_OUT = s.osc_keep;
endmodule // cwu_deadband

// ---- test/cwu_deadband_chk.sv ----
// concurrent checks on the bus, flag and reset behaviour of the waveform unit
`timescale 1ns/1ps

module cwu_deadband_chk (
    input  wire logic               MCLK_IN,               // system clock
    input  wire logic               SYS_RST_IN,            // async reset, active high
    input  wire logic [5:0]         AVS_ADDRESS_IN,        // byte address
    input  wire logic               AVS_READ_IN,           // read request
    input  wire logic               AVS_WRITE_IN,          // write request
    input  wire logic [3:0]         AVS_BYTEENABLE_IN,     // byte lanes
    input  wire cwu_pkg::cwu_word_t AVS_WRITEDATA_IN,      // write data
    input  wire logic               AVS_WAITREQUEST_OUT,   // stall
    input  wire cwu_pkg::cwu_word_t AVS_READDATA_OUT,      // read data
    input  wire logic               OUTPUT_FIRST_OUT,      // first output
    input  wire logic               OUTPUT_SECOND_OUT,     // second output
    input  wire logic               OUTPUT_THIRD_OUT,      // third output
    input  wire logic               OUTPUT_FOURTH_OUT,     // fourth output
    input  wire logic               SHUTDOWN_IRQ_FLAG_OUT  // sticky flag
);
    import cwu_pkg::*;
    logic clr_req;
    // a flag may only drop through a completed write-one-to-clear
    assign clr_req = AVS_WRITE_IN && !AVS_WAITREQUEST_OUT && AVS_ADDRESS_IN == 6'h24
                     && AVS_WRITEDATA_IN[0] && AVS_BYTEENABLE_IN[0];
    default clocking @(posedge MCLK_IN); endclocking
    default disable iff (SYS_RST_IN);

    AST_WAIT_ANSWER: assert property ((AVS_READ_IN || AVS_WRITE_IN) && AVS_WAITREQUEST_OUT
        |=> !AVS_WAITREQUEST_OUT) else $error("transfer not answered next cycle");
    AST_WAIT_ONE: assert property (!AVS_WAITREQUEST_OUT |=> AVS_WAITREQUEST_OUT)
        else $error("waitrequest low longer than one cycle");
    AST_WAIT_IDLE: assert property (!(AVS_READ_IN || AVS_WRITE_IN) && AVS_WAITREQUEST_OUT
        |=> AVS_WAITREQUEST_OUT) else $error("answer without request");
    AST_RDATA_UPPER: assert property (AVS_READ_IN && !AVS_WAITREQUEST_OUT
        |-> AVS_READDATA_OUT[31:8] == 24'h0) else $error("upper read bits not zero");
    AST_UNMAPPED: assert property (AVS_READ_IN && !AVS_WAITREQUEST_OUT && AVS_ADDRESS_IN > 6'h24
        |-> AVS_READDATA_OUT == 32'h0) else $error("unmapped read not zero");
    AST_RDATA_HOLD: assert property ($changed(AVS_READDATA_OUT)
        |-> AVS_READ_IN && !AVS_WAITREQUEST_OUT) else $error("read data moved off answer");
    AST_FLAG_CLEAR: assert property ($fell(SHUTDOWN_IRQ_FLAG_OUT) |-> $past(clr_req))
        else $error("flag dropped without clear write");
    AST_RESET_STATE: assert property ($fell(SYS_RST_IN) |-> AVS_WAITREQUEST_OUT
        && !SHUTDOWN_IRQ_FLAG_OUT && !(OUTPUT_FIRST_OUT || OUTPUT_SECOND_OUT
        || OUTPUT_THIRD_OUT || OUTPUT_FOURTH_OUT)) else $error("bad state after reset");
endmodule // cwu_deadband_chk

// ---- test/cwu_bridge_model.sv ----
// switch driver pair on one bridge leg: counts cycles where both switches conduct
`timescale 1ns/1ps

module cwu_bridge_model (
    input  wire logic clk_in,       // system clock
    input  wire logic rst_in,       // async reset
    input  wire logic high_side_in, // high-side gate drive
    input  wire logic low_side_in,  // low-side gate drive
    output int        overlap_out   // shoot-through cycles seen
);
    // drivers are modelled as instant, so any shared cycle is real shoot-through
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            overlap_out <= 0;
        end else if (high_side_in === 1'b1 && low_side_in === 1'b1) begin
            overlap_out <= overlap_out + 1;
        end
    end
endmodule // cwu_bridge_model

// ---- test/testbench.sv ----
// self-checking bench for the dead-band and auto-shutdown waveform unit
`timescale 1ns/1ps
`include "cwu_consts.svh"

module testbench;
    import cwu_pkg::*;
    localparam int DBF = 6;
    logic       clk, rst, rd, wr, data, sleep, o1, o2, o3, o4, flag, keep, wait_o;
    logic [5:0] addr;
    logic [3:0] be, sd_n;
    cwu_word_t  wdata, rdata_o, q;
    int         num_errors, samples_checked, overlaps;

    cwu_deadband cwu_deadband_i (.MCLK_IN(clk), .SYS_RST_IN(rst), .AVS_ADDRESS_IN(addr),
        .AVS_READ_IN(rd), .AVS_WRITE_IN(wr), .AVS_BYTEENABLE_IN(be), .AVS_WRITEDATA_IN(wdata),
        .AVS_WAITREQUEST_OUT(wait_o), .AVS_READDATA_OUT(rdata_o), .DATA_SRC_IN({4{data}}),
        .SHUTDOWN_N_IN(sd_n), .SLEEP_IN(sleep), .OUTPUT_FIRST_OUT(o1), .OUTPUT_SECOND_OUT(o2),
        .OUTPUT_THIRD_OUT(o3), .OUTPUT_FOURTH_OUT(o4), .SHUTDOWN_IRQ_FLAG_OUT(flag),
        .FAST_OSC_KEEP_OUT(keep));
    cwu_bridge_model cwu_bridge_model_i (.clk_in(clk), .rst_in(rst), .high_side_in(o1),
        .low_side_in(o2), .overlap_out(overlaps));

    task automatic check(input cwu_word_t got, input cwu_word_t exp, input string m);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %0t %s: got %h expected %h", $time, m, got, exp);
        end
    endtask
    task automatic check_outs(input logic [3:0] exp, input string m);
        check({28'h0, o1, o2, o3, o4}, {28'h0, exp}, m);
    endtask
    task automatic check_rng(input int got, input int lo, input int hi, input string m);
        samples_checked++;
        if (got < lo || got > hi) begin
            num_errors++;
            $display("[FAIL] %0t %s: %0d outside %0d..%0d", $time, m, got, lo, hi);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    // holds the request until waitrequest is sampled low; only the watchdog ends a hang
    task automatic bus(input logic w, input logic [5:0] a, input logic [7:0] d);
        @(posedge clk);
        rd <= !w; wr <= w; addr <= a; wdata <= {24'h0, d};
        do @(posedge clk); while (wait_o !== 1'b0);
        q = rdata_o;
        rd <= 1'b0; wr <= 1'b0;
    endtask
    // outputs hold the override (1001) until a rising data edge, then run (1010)
    task automatic resume();
        data <= 1'b0; tick(20); check_outs(4'h9, "held until rising edge");
        data <= 1'b1; tick(20); check_outs(4'hA, "resumed high");
    endtask

    task automatic t_reset();
        check_outs(4'h0, "outputs after reset");
        check({30'h0, wait_o, flag}, 32'h2, "wait and flag after reset");
        bus(1'b1, 6'h3C, 8'hFF);
        bus(1'b0, 6'h3C, 8'h00); check(q, 32'h0, "unmapped read");
    endtask
    task automatic t_start();
        bus(1'b1, `CWU_REG_CTRL, {5'h0, `CWU_MODE_HALF});
        bus(1'b1, `CWU_REG_POL, 8'h00);
        bus(1'b1, `CWU_REG_SRC, 8'h00);
        bus(1'b1, `CWU_REG_SDCTL, 8'h24);
        bus(1'b1, `CWU_REG_SDEN, 8'h01);
        bus(1'b1, `CWU_REG_DBR, 8'h01);
        bus(1'b1, `CWU_REG_DBF, 8'(DBF));
        bus(1'b1, `CWU_REG_CLK, 8'h00);
        bus(1'b1, `CWU_REG_CTRL, 8'h84); tick(10);
        check_outs(4'h9, "start in override");
        bus(1'b0, `CWU_REG_SDCTL, 8'h00); check({31'h0, q[7]}, 32'h1, "start shutdown");
        bus(1'b1, `CWU_REG_SDCTL, 8'h24); tick(10);
        resume();
        // clear the start-up flag so later flag checks see fresh events
        bus(1'b1, `CWU_REG_STAT, 8'h01); tick(2);
        check({31'h0, flag}, 32'h0, "flag cleared after start");
    endtask
    // drops the data input and measures first-off to second-on in half bridge
    task automatic fall_gap(input int lo, input int hi, input string m);
        int t1, t2;
        t1 = -1; t2 = -1;
        data <= 1'b0;
        for (int i = 0; i < 40; i++) begin
            @(posedge clk);
            if (o1 === 1'b0 && t1 < 0) t1 = i;
            if (o2 === 1'b1 && t2 < 0) t2 = i;
        end
        check_rng(t2 - t1, lo, hi, m);
    endtask
    task automatic t_fall();
        logic seen;
        seen = 1'b0;
        fall_gap(DBF, DBF + 1, "falling dead band");
        check_outs(4'h5, "low half bridge");
        data <= 1'b1; tick(20);
        data <= 1'b0; tick(2);
        data <= 1'b1;
        for (int i = 0; i < 30; i++) begin
            @(posedge clk);
            seen = seen | o2;
        end
        check({31'h0, seen}, 32'h0, "short low pulse suppressed");
    endtask
    // enabled: a new falling count waits for a fall and then a rise after the request
    task automatic t_load();
        data <= 1'b1; tick(20);
        bus(1'b1, `CWU_REG_DBF, 8'h02);
        bus(1'b1, `CWU_REG_CTRL, 8'hC4);
        bus(1'b0, `CWU_REG_CTRL, 8'h00); check({31'h0, q[6]}, 32'h1, "load pending");
        fall_gap(DBF, DBF + 1, "old count until loaded");
        data <= 1'b1; tick(20);
        bus(1'b0, `CWU_REG_CTRL, 8'h00); check({31'h0, q[6]}, 32'h0, "load done");
        fall_gap(2, 3, "new count after load");
        data <= 1'b1; tick(20);
    endtask
    task automatic t_fault();
        data <= 1'b0; sd_n <= 4'hD; tick(20);
        check_outs(4'h5, "disabled input ignored");
        sd_n <= 4'hE; tick(6);
        check_outs(4'h9, "fault override");
        check({31'h0, flag}, 32'h1, "flag on fault");
        bus(1'b1, `CWU_REG_SDCTL, 8'h24);
        bus(1'b0, `CWU_REG_SDCTL, 8'h00); check({31'h0, q[7]}, 32'h1, "clear refused");
        sd_n <= 4'hF; tick(10);
        check_outs(4'h9, "held by shutdown bit");
        bus(1'b1, `CWU_REG_STAT, 8'h01); tick(2);
        check({31'h0, flag}, 32'h0, "flag cleared");
        bus(1'b1, `CWU_REG_SDCTL, 8'h24); tick(10);
        resume();
    endtask
    task automatic t_auto();
        bus(1'b1, `CWU_REG_SDCTL, 8'hE4); tick(4);
        check({31'h0, flag}, 32'h1, "flag on software shutdown");
        bus(1'b0, `CWU_REG_SDCTL, 8'h00); check({30'h0, q[7:6]}, 32'h1, "auto clear");
        resume();
        sd_n <= 4'hE; tick(6);
        check_outs(4'h9, "fault with auto restart");
        sd_n <= 4'hF; tick(4);
        bus(1'b0, `CWU_REG_SDCTL, 8'h00); check({31'h0, q[7]}, 32'h0, "hw auto clear");
        resume();
    endtask
    task automatic t_osc();
        bus(1'b1, `CWU_REG_CLK, 8'h01); tick(2);
        check({31'h0, keep}, 32'h1, "oscillator kept");
        sleep <= 1'b1;
        data <= 1'b0; tick(60); check_outs(4'h5, "runs in sleep");
        data <= 1'b1; tick(60); check_outs(4'hA, "runs in sleep");
        sleep <= 1'b0;
        bus(1'b1, `CWU_REG_CLK, 8'h00); tick(2);
        check({31'h0, keep}, 32'h0, "oscillator released");
    endtask
    task automatic t_modes();
        for (int m = 0; m < 8; m++) begin
            bus(1'b1, `CWU_REG_CTRL, 8'h80 | 8'(m));
            bus(1'b0, `CWU_REG_CTRL, 8'h00); check({29'h0, q[2:0]}, 32'(m), "mode");
            tick(10);
            if (m > 5) check_outs(4'h0, "reserved mode");
        end
    endtask
    task automatic complete_run();
        if (num_errors == 0 && samples_checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    initial begin
        rst = 1'b1; rd = 1'b0; wr = 1'b0; addr = 6'h00; be = 4'hF; wdata = 32'h0;
        data = 1'b0; sleep = 1'b0; sd_n = 4'hF; num_errors = 0; samples_checked = 0;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_start();
        t_fall();
        t_load();
        t_fault();
        t_auto();
        t_osc();
        check(32'(overlaps), 32'h0, "leg shoot-through");
        t_modes();
        complete_run();
    end
    initial begin
        #100000;
        num_errors++;
        complete_run();
    end
endmodule // testbench

bind cwu_deadband cwu_deadband_chk cwu_deadband_chk_i (.MCLK_IN(MCLK_IN),
    .SYS_RST_IN(SYS_RST_IN), .AVS_ADDRESS_IN(AVS_ADDRESS_IN), .AVS_READ_IN(AVS_READ_IN),
    .AVS_WRITE_IN(AVS_WRITE_IN), .AVS_BYTEENABLE_IN(AVS_BYTEENABLE_IN),
    .AVS_WRITEDATA_IN(AVS_WRITEDATA_IN), .AVS_WAITREQUEST_OUT(AVS_WAITREQUEST_OUT),
    .AVS_READDATA_OUT(AVS_READDATA_OUT), .OUTPUT_FIRST_OUT(OUTPUT_FIRST_OUT),
    .OUTPUT_SECOND_OUT(OUTPUT_SECOND_OUT), .OUTPUT_THIRD_OUT(OUTPUT_THIRD_OUT),
    .OUTPUT_FOURTH_OUT(OUTPUT_FOURTH_OUT), .SHUTDOWN_IRQ_FLAG_OUT(SHUTDOWN_IRQ_FLAG_OUT));
